/* csar_defines.svh */
// Purpose: constants for the status and converter readback registers
// Assumes: byte-wide register port, offsets as printed
// Notes:   register offsets, field positions, reset values and the nominal setting code only; no logic here
//
// Summary of operation
// - bit 4 shows type-c device attached
// - bit 3 shows legacy charger attached
// - bit 2 high when bus below safe-zero with type-c enabled
// - bit 0 high when source power applied
// - bits 5:4 give plug orientation code
// - current code scaled 116mV/256 over resistance
// - voltage code scaled 19.8V/256 at setting 000
// - temperature is 3.5 times code minus 270
// - status registers read-only, writes ignored
`ifndef CSAR_DEFINES_SVH
`define CSAR_DEFINES_SVH

// ****************************************
// register offsets
// ****************************************
`define CSAR_ADDR_STATUS0     8'h0d
`define CSAR_ADDR_STATUS1     8'h0e
`define CSAR_ADDR_CURRENT     8'h10
`define CSAR_ADDR_VOLTAGE     8'h11
`define CSAR_ADDR_TEMP        8'h12

// ****************************************
// field positions
// ****************************************
`define CSAR_BIT_TYPEC_ATT    4
`define CSAR_BIT_LEGACY_ATT   3
`define CSAR_BIT_BUS_SAFE     2
`define CSAR_BIT_SRC_POWER    0
`define CSAR_ORIENT_LSB       4
`define CSAR_STATE_LSB        0

// ****************************************
// reset values and the nominal voltage setting code
// ****************************************
`define CSAR_RST_BYTE         8'h00
`define CSAR_RST_ORIENT       2'h0
`define CSAR_RST_STATE        4'h0
`define CSAR_SETTING_NOMINAL  3'h0

`endif

/* csar_pkg.sv */
// Purpose: shared types for the readback registers
// Assumes: nothing beyond the defines header
// Notes:   orientation codes and the register byte type
package csar_pkg;

  typedef enum logic [1:0] {
    CSAR_ORIENT_NONE = 2'b00,
    CSAR_ORIENT_CC1  = 2'b01,
    CSAR_ORIENT_CC2  = 2'b10,
    CSAR_ORIENT_RSVD = 2'b11
  } csar_orient_e;

  typedef logic [7:0] csar_byte_t;

endpackage

/* csar_readback.sv */
// Purpose: read-only status and converter result registers
// Assumes: analog front end, attach and charger logic supply live values
// Notes:   byte register port; values are captured into flops once two synchronised samples agree
`timescale 1ns/1ns
`include "csar_defines.svh"
module csar_readback
  import csar_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  // live status from the attach and charger logic
  input  wire logic       typec_attached_flag,
  input  wire logic       legacy_charger_attached_flag,
  input  wire logic       bus_voltage_safe_flag,
  input  wire logic       source_power_applied_flag,
  input  wire logic [1:0] plug_orientation_field,
  input  wire logic [3:0] connection_state_field,
  input  wire logic       typec_enable,
  // converter results
  input  wire logic [7:0] load_current_code,
  input  wire logic [7:0] output_voltage_code,
  input  wire logic [7:0] die_temperature_code,
  input  wire logic [2:0] output_voltage_setting,
  // register port
  input  wire logic       reg_rd,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            reg_hit,
  output logic            voltage_scale_nominal
);

  // ****************************************
  // input synchronisation
  // ****************************************
  localparam int SW = 38;

  logic [SW-1:0] raw_in;
  logic [SW-1:0] sync_in;

  assign raw_in = {typec_attached_flag, legacy_charger_attached_flag, bus_voltage_safe_flag,
                   source_power_applied_flag, plug_orientation_field, connection_state_field,
                   typec_enable, load_current_code, output_voltage_code, die_temperature_code,
                   output_voltage_setting};

  csar_sync #(.W(SW)) u_sync (
    .clock (clock),
    .rst   (rst),
    .d     (raw_in),
    .q     (sync_in)
  );

  wire       s_typec   = sync_in[37];
  wire       s_legacy  = sync_in[36];
  wire       s_safe    = sync_in[35];
  wire       s_power   = sync_in[34];
  wire [1:0] s_orient  = sync_in[33:32];
  wire [3:0] s_state   = sync_in[31:28];
  wire       s_tc_en   = sync_in[27];
  wire [7:0] s_current = sync_in[26:19];
  wire [7:0] s_voltage = sync_in[18:11];
  wire [7:0] s_temp    = sync_in[10:3];
  wire [2:0] s_setting = sync_in[2:0];

  // ****************************************
  // word coherence
  // ****************************************
  // a word is taken only once two synchronised samples agree, so a code caught mid-change
  // never reaches software; limitation: a field that never stops moving keeps its last image
  logic [SW-1:0] hold_r;
  wire  [SW-1:0] same      = ~(sync_in ^ hold_r);
  wire           st0_still = &{same[37:34], same[27]};
  wire           st1_still = &same[33:28];
  wire           cur_still = &same[26:19];
  wire           vlt_still = &same[18:11];
  wire           tmp_still = &same[10:3];
  wire           set_still = &same[2:0];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hold_r <= '0;
    end else begin
      hold_r <= sync_in;
    end
  end

  // ****************************************
  // register images
  // ****************************************
  csar_byte_t status0_r;
  csar_byte_t status1_r;
  csar_byte_t current_r;
  csar_byte_t voltage_r;
  csar_byte_t temp_r;
  logic       nominal_r;

  csar_byte_t   status0_nxt;
  csar_byte_t   status1_nxt;
  csar_orient_e orient;

  // unused code 11 is mapped to no attach rather than shown to software
  assign orient = (s_orient == CSAR_ORIENT_RSVD) ? CSAR_ORIENT_NONE : csar_orient_e'(s_orient);

  always_comb begin
    status0_nxt = `CSAR_RST_BYTE;
    status0_nxt[`CSAR_BIT_TYPEC_ATT]  = s_typec;
    status0_nxt[`CSAR_BIT_LEGACY_ATT] = s_legacy;
    // safe indication only means something with type-c enabled
    status0_nxt[`CSAR_BIT_BUS_SAFE]   = s_safe & s_tc_en;
    status0_nxt[`CSAR_BIT_SRC_POWER]  = s_power;
    status1_nxt = `CSAR_RST_BYTE;
    status1_nxt[`CSAR_ORIENT_LSB +: 2] = orient;
    status1_nxt[`CSAR_STATE_LSB +: 4]  = s_state;
  end

  // raw codes are stored; scaling is applied by software
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      status0_r <= `CSAR_RST_BYTE;
      status1_r <= `CSAR_RST_BYTE;
      current_r <= `CSAR_RST_BYTE;
      voltage_r <= `CSAR_RST_BYTE;
      temp_r    <= `CSAR_RST_BYTE;
      nominal_r <= 1'b1;
    end else begin
      if (st0_still) begin
        status0_r <= status0_nxt;
      end
      if (st1_still) begin
        status1_r <= status1_nxt;
      end
      if (cur_still) begin
        current_r <= s_current;
      end
      if (vlt_still) begin
        voltage_r <= s_voltage;
      end
      if (tmp_still) begin
        temp_r    <= s_temp;
      end
      if (set_still) begin
        nominal_r <= (s_setting == `CSAR_SETTING_NOMINAL);
      end
    end
  end

  // ****************************************
  // register read port
  // ****************************************
  wire hit_s0  = (reg_addr == `CSAR_ADDR_STATUS0);
  wire hit_s1  = (reg_addr == `CSAR_ADDR_STATUS1);
  wire hit_cur = (reg_addr == `CSAR_ADDR_CURRENT);
  wire hit_vlt = (reg_addr == `CSAR_ADDR_VOLTAGE);
  wire hit_tmp = (reg_addr == `CSAR_ADDR_TEMP);
  wire hit_any = hit_s0 | hit_s1 | hit_cur | hit_vlt | hit_tmp;

  wire [7:0] rd_mux = hit_s0  ? status0_r :
                      hit_s1  ? status1_r :
                      hit_cur ? current_r :
                      hit_vlt ? voltage_r :
                      hit_tmp ? temp_r    : `CSAR_RST_BYTE;

  // writes carry no storage here; they are acknowledged and dropped
  wire       wr_dropped = reg_wr & ~reg_rd;
  wire [7:0] wr_ignored = reg_wdata;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata             <= `CSAR_RST_BYTE;
      reg_hit               <= 1'b0;
      voltage_scale_nominal <= 1'b1;
    end else begin
      reg_rdata             <= reg_rd ? rd_mux : `CSAR_RST_BYTE;
      reg_hit               <= (reg_rd | wr_dropped) & hit_any;
      voltage_scale_nominal <= nominal_r;
    end
  end

endmodule

/* csar_readback_assertions.sv */
// Purpose: port checks for the readback registers
// Assumes: live inputs held steady a while before a read is judged
// Notes:   stab_r counts cycles without a live input change, so sync latency never matters
`timescale 1ns/1ns
module csar_chk (
  input wire logic       clock, rst, reg_rd, reg_wr, reg_hit, voltage_scale_nominal, typec_enable,
  input wire logic       typec_attached_flag, legacy_charger_attached_flag, bus_voltage_safe_flag,
  input wire logic       source_power_applied_flag,
  input wire logic [1:0] plug_orientation_field,
  input wire logic [3:0] connection_state_field,
  input wire logic [2:0] output_voltage_setting,
  input wire logic [7:0] load_current_code, output_voltage_code, die_temperature_code, reg_addr, reg_rdata
);
  wire  [37:0] live = {typec_attached_flag, legacy_charger_attached_flag, bus_voltage_safe_flag,
    source_power_applied_flag, typec_enable, plug_orientation_field, connection_state_field,
    output_voltage_setting, load_current_code, output_voltage_code, die_temperature_code};
  logic [37:0] live_r;
  logic [3:0]  stab_r;
  wire         ok = stab_r > 4'h5;
  wire         mapped = reg_addr inside {8'h0d, 8'h0e, 8'h10, 8'h11, 8'h12};
  // expectations use last cycle's inputs, matching the edge at which the answer was taken
  wire         p_ta = live_r[37];
  wire         p_la = live_r[36];
  wire         p_bs = live_r[35];
  wire         p_sp = live_r[34];
  wire         p_en = live_r[33];
  wire  [1:0]  p_or = live_r[32:31];
  wire  [3:0]  p_st = live_r[30:27];
  wire  [2:0]  p_vs = live_r[26:24];
  wire  [7:0]  p_ic = live_r[23:16];
  wire  [7:0]  p_vc = live_r[15:8];
  wire  [7:0]  p_tc = live_r[7:0];
  wire  [1:0]  ori  = (p_or == 2'b11) ? 2'b00 : p_or;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      live_r <= '0;
      stab_r <= 4'h0;
    end else begin
      live_r <= live;
      stab_r <= (live != live_r) ? 4'h0 : stab_r + {3'h0, stab_r != 4'hf};
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  status_word_a:
    assert property ($past(reg_rd && reg_addr == 8'h0d) && ok |-> reg_rdata == {3'h0, p_ta,
      p_la, p_bs & p_en, 1'b0, p_sp})
      else $error("status0 image wrong");
  orient_state_a:
    assert property ($past(reg_rd && reg_addr == 8'h0e) && ok |-> reg_rdata == {2'h0, ori, p_st})
      else $error("status1 image wrong");
  current_code_a:
    assert property ($past(reg_rd && reg_addr == 8'h10) && ok |-> reg_rdata == p_ic) else $error("current");
  voltage_code_a:
    assert property ($past(reg_rd && reg_addr == 8'h11) && ok |-> reg_rdata == p_vc) else $error("volt");
  temp_code_a:
    assert property ($past(reg_rd && reg_addr == 8'h12) && ok |-> reg_rdata == p_tc) else $error("temp");
  scale_flag_a:
    assert property (ok |-> voltage_scale_nominal == (p_vs == 3'h0)) else $error("scale flag");
  quiet_rdata_a:
    assert property ($past(!reg_rd || !mapped) |-> reg_rdata == 8'h00) else $error("rdata not zero");
  hit_flag_a:
    assert property (reg_hit == $past((reg_rd || reg_wr) && mapped)) else $error("hit flag wrong");
  cover property ($past(reg_rd) && reg_hit && ok);
  cover property ($past(reg_wr) && reg_hit);
  cover property ($past(reg_rd) && !reg_hit);
endmodule

/* csar_readback_tb.sv */
// Purpose: self-checking bench for the readback registers
// Assumes: inputs change 1 ns after a rising edge
// Notes:   reads wait 8 cycles after inputs change so the synchronisers have settled
`timescale 1ns/1ns
module csar_readback_tb;
  logic       clock = 1'b0, rst = 1'b1, ta = 1'b0, la = 1'b0, bs = 1'b0, sp = 1'b0, en = 1'b0, rd = 1'b0, wr = 1'b0;
  logic [1:0] ori = 2'h0;
  logic [2:0] vs = 3'h0;
  logic [3:0] st = 4'h0;
  logic [7:0] ic = 8'h00, vc = 8'h00, tc = 8'h00, ad = 8'h00;
  logic [7:0] addrs [5] = '{8'h0d, 8'h0e, 8'h10, 8'h11, 8'h12};
  logic [7:0] codes [8] = '{8'h00, 8'h01, 8'h7f, 8'h80, 8'hfe, 8'hff, 8'h5a, 8'ha5};
  wire  [7:0] q;
  wire        h, vn;
  int         fail_count = 0, compares = 0;
  always #2 clock = ~clock;
  csar_readback csar_readback_inst (.clock(clock), .rst(rst), .typec_attached_flag(ta),
    .legacy_charger_attached_flag(la), .bus_voltage_safe_flag(bs), .source_power_applied_flag(sp),
    .plug_orientation_field(ori), .connection_state_field(st), .typec_enable(en), .load_current_code(ic),
    .output_voltage_code(vc), .die_temperature_code(tc), .output_voltage_setting(vs), .reg_rd(rd),
    .reg_wr(wr), .reg_addr(ad), .reg_wdata(8'hff), .reg_rdata(q), .reg_hit(h), .voltage_scale_nominal(vn));
  task check(string n, logic [7:0] s, logic [7:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task give_verdict;
    $display("mismatches %0d of %0d compares", fail_count, compares);
    if (fail_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one-cycle strobe; answer is sampled in the cycle after the taking edge
  task access(logic [7:0] a, logic w);
    @(posedge clock);
    #1 rd = !w;
    wr = w;
    ad = a;
    @(posedge clock);
    #1 rd = 1'b0;
    wr = 1'b0;
  endtask
  task settle;
    repeat (8) @(posedge clock);
    #1;
  endtask
  task t_reset;
    repeat (3) @(posedge clock);
    check("reset rdata", q, 8'h00);
    check("reset nominal", {7'h0, vn}, 8'h01);
    #1 rst = 1'b0;
    for (int i = 0; i < 5; i++) begin
      access(addrs[i], 1'b0);
      check("reset value", q, 8'h00);
    end
  endtask
  task t_status0;
    for (int i = 0; i < 32; i++) begin
      {en, ta, la, bs, sp} = i[4:0];
      settle;
      access(8'h0d, 1'b0);
      check("status0", q, {3'h0, i[3], i[2], i[1] & i[4], 1'b0, i[0]});
    end
  endtask
  task t_status1;
    for (int i = 0; i < 64; i++) begin
      {ori, st} = i[5:0];
      settle;
      access(8'h0e, 1'b0);
      check("status1", q, {2'h0, (i[5:4] == 2'b11) ? 2'b00 : i[5:4], i[3:0]});
    end
  endtask
  task t_codes;
    for (int i = 0; i < 8; i++) begin
      ic = codes[i];
      vc = ~codes[i];
      tc = codes[i] ^ 8'h3c;
      vs = i[2:0];
      settle;
      check("nominal scale", {7'h0, vn}, {7'h0, i == 0});
      for (int k = 0; k < 3; k++) begin
        access(addrs[k + 2], 1'b0);
        check("code", q, (k == 0) ? ic : (k == 1) ? vc : tc);
      end
    end
  endtask
  // writes and a current read come first, then an unmapped read and a status1 read back-to-back
  task t_refuse;
    {ori, st} = 6'h25;
    settle;
    for (int i = 0; i < 5; i++) begin
      access(addrs[i], 1'b1);
      check("write hit", {7'h0, h}, 8'h01);
    end
    access(8'h10, 1'b0);
    check("code after write", q, ic);
    @(posedge clock);
    #1 rd = 1'b1;
    ad = 8'h13;
    @(posedge clock);
    #1 ad = 8'h0e;
    check("unmapped rdata", q, 8'h00);
    check("unmapped hit", {7'h0, h}, 8'h00);
    @(posedge clock);
    #1 rd = 1'b0;
    check("status1 after write", q, 8'h25);
    check("status1 hit", {7'h0, h}, 8'h01);
  endtask
  initial begin
    t_reset;
    t_status0;
    t_status1;
    t_codes;
    t_refuse;
    give_verdict;
  end
  initial begin
    #40000;
    fail_count++;
    give_verdict;
  end
endmodule
bind csar_readback csar_chk csar_chk_inst (.*);

/* csar_sync.sv */
// Purpose: two-flop synchroniser for a bus of pin-level inputs
// Assumes: inputs asynchronous to clock
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ns
module csar_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule
